// ==== vrss_top.sv ====
// Operation
// - Speed-attained turns on when measured speed exceeds the attained threshold.
// - Speed-attained uses a 10 r/min hysteresis band against chatter.
// - Coincidence reference is the command before or after the ramp.
// - Coincidence turns on only once difference falls to range minus 10.
// - Coincidence turns off only once difference exceeds range plus 10.
// - The input command is ramped internally for a soft start.
// - Acceleration setting is milliseconds to rise from zero to 1000 r/min.
// - Deceleration setting is milliseconds to fall from 1000 r/min to zero.
// - Ramp time scales linearly with target speed over 1000 r/min.
// - Ramp corners are rounded into an S-curve of 0 to 1000 ms.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

package vrss_pkg;
  localparam logic [7:0] OFF_VCMD = 8'h00;
  localparam logic [7:0] OFF_ACCEL = 8'h04;
  localparam logic [7:0] OFF_DECEL = 8'h08;
  localparam logic [7:0] OFF_SCURVE = 8'h0C;
  localparam logic [7:0] OFF_ATTAIN = 8'h10;
  localparam logic [7:0] OFF_MATCH = 8'h14;
  localparam logic [7:0] OFF_CTRL = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_RAMPED = 8'h20;
  localparam int CTRL_REF_BIT = 0;
  localparam int ST_ATTAIN_BIT = 0;
  localparam int ST_MATCH_BIT = 1;
  localparam int ST_RAMPING_BIT = 2;
  localparam logic [13:0] ACCEL_RST = 14'h0000;
  localparam logic [13:0] DECEL_RST = 14'h0000;
  localparam logic [9:0] SCURVE_RST = 10'h000;
  localparam logic [14:0] ATTAIN_RST = 15'h03E8;
  localparam logic [14:0] MATCH_RST = 15'h0032;
  localparam logic [16:0] HYST_RPM = 17'h0_000A;
  localparam int CLK_HZ = 25000000;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / (1000000000 / CLK_HZ);
  localparam logic [4:0] US_LAST = 5'(US_CYC - 1);
  localparam logic [9:0] MS_LAST = 10'h3E7;
endpackage

module vrss_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] motor_speed,
  output logic signed [15:0] ramped_cmd,
  output logic speed_attained_out,
  output logic speed_match_out
);

  typedef struct packed {
    logic signed [15:0] vcmd;
    logic [13:0] accel;
    logic [13:0] decel;
    logic [9:0] scurve;
    logic [14:0] attain_thr;
    logic [14:0] match_rng;
    logic ref_pre;
    logic [4:0] us_div;
    logic [9:0] ms_div;
    logic [13:0] step_cnt;
    logic signed [15:0] lin;
    logic [9:0] idx;
    logic [9:0] fill;
    logic signed [26:0] sum;
    logic div_go;
    logic avg_neg;
    logic signed [15:0] smooth;
    logic signed [15:0] out_cmd;
    logic attained;
    logic match;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } vrss_state_t;

  vrss_state_t st_reg;
  vrss_state_t st_next;
  logic signed [15:0] hist_mem [0:1023];
  logic us_tick;
  logic ms_tick;
  logic away;
  logic [13:0] interval;
  logic mapped;
  logic [31:0] rd_word;
  logic [16:0] mag_motor;
  logic [16:0] cmd_diff;
  logic signed [15:0] ref_cmd;
  logic signed [15:0] oldest;
  logic [25:0] div_q;
  logic div_done;
  logic wr_en;
  logic [26:0] sum_abs;

  function automatic logic [16:0] vrss_mag(input logic signed [16:0] v);
    vrss_mag = v[16] ? 17'(-v) : v;
  endfunction

  function automatic logic vrss_mapped(input logic [7:0] a);
    vrss_mapped = (a == vrss_pkg::OFF_VCMD) || (a == vrss_pkg::OFF_ACCEL) ||
      (a == vrss_pkg::OFF_DECEL) || (a == vrss_pkg::OFF_SCURVE) ||
      (a == vrss_pkg::OFF_ATTAIN) || (a == vrss_pkg::OFF_MATCH) ||
      (a == vrss_pkg::OFF_CTRL) || (a == vrss_pkg::OFF_STATUS) ||
      (a == vrss_pkg::OFF_RAMPED);
  endfunction

  vrss_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(st_reg.div_go),
    .dividend(sum_abs[25:0]),
    .divisor(st_reg.fill),
    .quotient(div_q),
    .done(div_done)
  );

  always_comb begin
    st_next = st_reg;
    us_tick = (st_reg.us_div == vrss_pkg::US_LAST);
    ms_tick = us_tick && (st_reg.ms_div == vrss_pkg::MS_LAST);
    mapped = vrss_mapped(paddr);
    wr_en = psel && penable && st_reg.pready && pwrite && !st_reg.pslverr;
    oldest = hist_mem[st_reg.idx];
    // The divider works on the magnitude; avg_neg puts the sign back.
    sum_abs = st_reg.sum[26] ? 27'(-st_reg.sum) : st_reg.sum;
    rd_word = 32'h0000_0000;
    unique case (paddr)
      vrss_pkg::OFF_VCMD: rd_word = {{16{st_reg.vcmd[15]}}, st_reg.vcmd};
      vrss_pkg::OFF_ACCEL: rd_word = {18'h0_0000, st_reg.accel};
      vrss_pkg::OFF_DECEL: rd_word = {18'h0_0000, st_reg.decel};
      vrss_pkg::OFF_SCURVE: rd_word = {22'h00_0000, st_reg.scurve};
      vrss_pkg::OFF_ATTAIN: rd_word = {17'h0_0000, st_reg.attain_thr};
      vrss_pkg::OFF_MATCH: rd_word = {17'h0_0000, st_reg.match_rng};
      vrss_pkg::OFF_CTRL: rd_word = {31'h0000_0000, st_reg.ref_pre};
      vrss_pkg::OFF_STATUS: begin
        rd_word[vrss_pkg::ST_ATTAIN_BIT] = st_reg.attained;
        rd_word[vrss_pkg::ST_MATCH_BIT] = st_reg.match;
        rd_word[vrss_pkg::ST_RAMPING_BIT] = (st_reg.lin != st_reg.vcmd);
      end
      vrss_pkg::OFF_RAMPED: rd_word = {{16{st_reg.out_cmd[15]}}, st_reg.out_cmd};
      default: rd_word = 32'h0000_0000;
    endcase

    // The answer is prepared in the setup phase so that every bus output
    // is a flop and the access phase never waits.
    st_next.pready = psel && !penable;
    if (psel && !penable) begin
      st_next.pslverr = !mapped;
      st_next.prdata = (!pwrite && mapped) ? rd_word : 32'h0000_0000;
    end else begin
      st_next.pslverr = 1'b0;
    end

    if (wr_en) begin
      unique case (paddr)
        vrss_pkg::OFF_VCMD: st_next.vcmd = pwdata[15:0];
        vrss_pkg::OFF_ACCEL: st_next.accel = pwdata[13:0];
        vrss_pkg::OFF_DECEL: st_next.decel = pwdata[13:0];
        vrss_pkg::OFF_SCURVE: begin
          // A new window length restarts the average from empty.
          st_next.scurve = pwdata[9:0];
          st_next.idx = 10'h000;
          st_next.fill = 10'h000;
          st_next.sum = 27'h000_0000;
        end
        vrss_pkg::OFF_ATTAIN: st_next.attain_thr = pwdata[14:0];
        vrss_pkg::OFF_MATCH: st_next.match_rng = pwdata[14:0];
        vrss_pkg::OFF_CTRL: st_next.ref_pre = pwdata[vrss_pkg::CTRL_REF_BIT];
        default: st_next.vcmd = st_reg.vcmd;
      endcase
    end

    st_next.us_div = us_tick ? 5'h00 : st_reg.us_div + 5'h01;
    if (us_tick) begin
      st_next.ms_div = ms_tick ? 10'h000 : st_reg.ms_div + 10'h001;
    end

    // Moving away from zero accelerates; toward zero decelerates, so a reversal decelerates only down to zero.
    away = (st_reg.lin >= 0 && st_reg.vcmd > st_reg.lin) ||
           (st_reg.lin <= 0 && st_reg.vcmd < st_reg.lin);
    interval = away ? st_reg.accel : st_reg.decel;
    // One r/min step every interval microseconds gives interval ms per
    // 1000 r/min, so ramp time grows linearly with the target speed.
    if (st_reg.lin == st_reg.vcmd) begin
      st_next.step_cnt = 14'h0000;
    end else if (interval == 14'h0000) begin
      st_next.lin = st_reg.vcmd;
      st_next.step_cnt = 14'h0000;
    end else if (us_tick) begin
      if (st_reg.step_cnt >= interval - 14'h0001) begin
        st_next.step_cnt = 14'h0000;
        st_next.lin = (st_reg.vcmd > st_reg.lin) ?
                      st_reg.lin + 16'sd1 : st_reg.lin - 16'sd1;
      end else begin
        st_next.step_cnt = st_reg.step_cnt + 14'h0001;
      end
    end

    // The S-curve is a moving average of the linear ramp over the curve
    // time, sampled once a millisecond; it rounds both corners equally.
    st_next.div_go = 1'b0;
    if (ms_tick && st_reg.scurve != 10'h000 && !wr_en) begin
      st_next.sum = st_reg.sum + 27'(st_reg.lin) -
        ((st_reg.fill == st_reg.scurve) ? 27'(oldest) : 27'sd0);
      st_next.fill = (st_reg.fill == st_reg.scurve) ?
                     st_reg.fill : st_reg.fill + 10'h001;
      st_next.idx = (st_reg.idx == st_reg.scurve - 10'h001) ?
                    10'h000 : st_reg.idx + 10'h001;
      st_next.div_go = 1'b1;
    end
    if (st_reg.div_go) begin
      st_next.avg_neg = st_reg.sum[26];
    end
    if (div_done) begin
      st_next.smooth = st_reg.avg_neg ? 16'(-div_q) : div_q[15:0];
    end
    st_next.out_cmd = (st_reg.scurve == 10'h000) ?
                      st_reg.lin : st_reg.smooth;

    mag_motor = vrss_mag(17'(motor_speed));
    if (!st_reg.attained) begin
      st_next.attained = mag_motor > {2'b00, st_reg.attain_thr};
    end else begin
      st_next.attained = $signed(mag_motor) >=
        $signed({2'b00, st_reg.attain_thr} - vrss_pkg::HYST_RPM);
    end

    ref_cmd = st_reg.ref_pre ? st_reg.vcmd : st_reg.out_cmd;
    cmd_diff = vrss_mag(17'(ref_cmd) - 17'(motor_speed));
    if (!st_reg.match) begin
      st_next.match = $signed({1'b0, cmd_diff}) <=
        $signed({3'b000, st_reg.match_rng} - 18'(vrss_pkg::HYST_RPM));
    end else begin
      st_next.match = cmd_diff <=
        {2'b00, st_reg.match_rng} + vrss_pkg::HYST_RPM;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.accel <= vrss_pkg::ACCEL_RST;
      st_reg.decel <= vrss_pkg::DECEL_RST;
      st_reg.scurve <= vrss_pkg::SCURVE_RST;
      st_reg.attain_thr <= vrss_pkg::ATTAIN_RST;
      st_reg.match_rng <= vrss_pkg::MATCH_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge pclk) begin
    if (ms_tick && st_reg.scurve != 10'h000 && !wr_en) begin
      hist_mem[st_reg.idx] <= st_reg.lin;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign ramped_cmd = st_reg.out_cmd;
  assign speed_attained_out = st_reg.attained;
  assign speed_match_out = st_reg.match;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");

  a_attain_rise: assert property (
    !st_reg.attained && (mag_motor > {2'b00, st_reg.attain_thr})
    |=> speed_attained_out)
    else $error("attained output missed the threshold crossing");

  a_attain_hyst: assert property (
    st_reg.attained && ({2'b00, st_reg.attain_thr} >= vrss_pkg::HYST_RPM) &&
    (mag_motor + vrss_pkg::HYST_RPM >= {2'b00, st_reg.attain_thr})
    |=> speed_attained_out)
    else $error("attained output dropped inside the hysteresis band");

  a_match_on: assert property (
    !st_reg.match && st_reg.match_rng >= 15'h000A &&
    (cmd_diff + vrss_pkg::HYST_RPM <= {2'b00, st_reg.match_rng})
    |=> speed_match_out)
    else $error("coincidence did not turn on below range minus 10");

  a_match_off: assert property (
    st_reg.match && (cmd_diff > {2'b00, st_reg.match_rng} + vrss_pkg::HYST_RPM)
    |=> !speed_match_out)
    else $error("coincidence did not turn off above range plus 10");

  a_match_stay: assert property (
    !st_reg.match && (cmd_diff > {2'b00, st_reg.match_rng})
    |=> !speed_match_out)
    else $error("coincidence turned on outside the range");

  a_ramp_step: assert property (
    (st_reg.accel != 14'h0000) && (st_reg.decel != 14'h0000)
    |=> (st_reg.lin - $past(st_reg.lin) <= 16'sd1) &&
        ($past(st_reg.lin) - st_reg.lin <= 16'sd1))
    else $error("ramp moved by more than one step");

  a_ramp_tick: assert property (
    (interval != 14'h0000) && !us_tick |=> $stable(st_reg.lin))
    else $error("ramp stepped between microsecond ticks");

  a_pass_thru: assert property (
    (st_reg.accel == 14'h0000 && st_reg.decel == 14'h0000 &&
     st_reg.scurve == 10'h000 && $stable(st_reg.vcmd)) [*2]
    |=> ramped_cmd == $past(st_reg.vcmd))
    else $error("ramped command differs with ramps disabled");

  a_ramp_jump: assert property (
    (interval == 14'h0000) && (st_reg.lin != st_reg.vcmd)
    |=> st_reg.lin == $past(st_reg.vcmd))
    else $error("ramp with zero time did not jump to the command");

  a_ramp_toward: assert property (
    st_reg.vcmd > st_reg.lin
    |=> (st_reg.lin >= $past(st_reg.lin)) &&
        (st_reg.lin <= $past(st_reg.vcmd)))
    else $error("ramp moved away from or past the command");

  a_avg_hold: assert property (
    !div_done |=> $stable(st_reg.smooth))
    else $error("smoothed command changed without a new average");

endmodule // vrss_top

`default_nettype wire

// ==== vrss_div.sv ====
`timescale 1ns/1ps
`default_nettype none

// Restoring divider, one quotient bit per clock. The smoothing stage
// needs one quotient per millisecond, so a slow serial divider is far
// cheaper than a combinational one and still finishes in time.
module vrss_div (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [25:0] dividend,
  input wire logic [9:0] divisor,
  output logic [25:0] quotient,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic [4:0] cnt;
    logic [25:0] quo;
    logic [10:0] rem;
    logic [9:0] dvs;
    logic done;
  } vrss_div_state_t;

  vrss_div_state_t st_reg;
  vrss_div_state_t st_next;
  logic [10:0] trial;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    trial = {st_reg.rem[9:0], st_reg.quo[25]};
    if (start) begin
      st_next.busy = 1'b1;
      st_next.cnt = 5'd0;
      st_next.quo = dividend;
      st_next.rem = 11'h000;
      st_next.dvs = divisor;
    end else if (st_reg.busy) begin
      st_next.quo = {st_reg.quo[24:0], 1'b0};
      if (trial >= {1'b0, st_reg.dvs}) begin
        st_next.rem = trial - {1'b0, st_reg.dvs};
        st_next.quo[0] = 1'b1;
      end else begin
        st_next.rem = trial;
      end
      st_next.cnt = st_reg.cnt + 5'd1;
      if (st_reg.cnt == 5'd25) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign quotient = st_reg.quo;
  assign done = st_reg.done;

endmodule // vrss_div

`default_nettype wire

// ==== vrss_host.sv ====
`timescale 1ns/1ps
`default_nettype none

// Host controller model: an APB master carrying command and settings.
module vrss_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // Idle address and data are inverted so a stale value never helps.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
endmodule // vrss_host

`default_nettype wire

// ==== vrss_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic signed [15:0] motor_speed, ramped_cmd;
  logic speed_attained_out, speed_match_out;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;

  vrss_top i_vrss_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_speed(motor_speed), .ramped_cmd(ramped_cmd),
    .speed_attained_out(speed_attained_out),
    .speed_match_out(speed_match_out));
  vrss_host i_vrss_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The whole run needs about 75000 cycles, mostly the S-curve wait.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic check_word(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp,
    input logic got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_vrss_host.wr(a, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q,
    output logic e);
    i_vrss_host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask

  task automatic set_speed(input logic signed [15:0] v);
    @(posedge pclk);
    motor_speed <= v;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    logic [7:0] offs [8] = '{vrss_pkg::OFF_VCMD, vrss_pkg::OFF_ACCEL,
      vrss_pkg::OFF_DECEL, vrss_pkg::OFF_SCURVE, vrss_pkg::OFF_ATTAIN,
      vrss_pkg::OFF_MATCH, vrss_pkg::OFF_CTRL, vrss_pkg::OFF_STATUS};
    logic [31:0] exps [8] = '{32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_03E8, 32'h0000_0032,
      32'h0000_0000, 32'h0000_0002};
    for (int i = 0; i < 8; i++) begin
      rd(offs[i], q, e);
      check_word("reset value", exps[i], q);
      check_bit("mapped read error", 1'b0, e);
    end
    i_vrss_host.xfer(1'b1, 8'h24, 32'hFFFF_FFFF, q, e);
    check_bit("unmapped write error", 1'b1, e);
    rd(8'h24, q, e);
    check_word("unmapped read data", 32'h0000_0000, q);
    wr(vrss_pkg::OFF_STATUS, 32'h0000_0005);
    rd(vrss_pkg::OFF_STATUS, q, e);
    check_word("status after write", 32'h0000_0002, q);
    $display("test reset done");
  endtask

  task automatic t_pass();
    logic [31:0] q;
    logic e;
    wr(vrss_pkg::OFF_ACCEL, 32'h0000_0000);
    wr(vrss_pkg::OFF_DECEL, 32'h0000_0000);
    wr(vrss_pkg::OFF_VCMD, 32'h0000_01F4);
    repeat (2) @(posedge pclk);
    #1 check_word("ramped 500", 32'h0000_01F4, 32'(ramped_cmd));
    wr(vrss_pkg::OFF_VCMD, 32'hFFFF_FFE2);
    repeat (2) @(posedge pclk);
    #1 check_word("ramped -30", 32'hFFFF_FFE2, 32'(ramped_cmd));
    rd(vrss_pkg::OFF_RAMPED, q, e);
    check_word("ramped register", 32'hFFFF_FFE2, q);
    $display("test passthrough done");
  endtask

  task automatic t_attain();
    logic [15:0] sp [6] = '{16'h03E8, 16'h03E9, 16'h03DE, 16'h03DD,
      16'hFC17, 16'h0000};
    logic ex [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++) begin
      set_speed(sp[i]);
      check_bit("attained", ex[i], speed_attained_out);
    end
    $display("test attained done");
  endtask

  task automatic t_match();
    logic [15:0] sp [5] = '{16'h01B7, 16'h01C2, 16'h01CC, 16'h01B8,
      16'h01B7};
    logic ex [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] q;
    logic e;
    wr(vrss_pkg::OFF_VCMD, 32'h0000_01F4);
    for (int i = 0; i < 5; i++) begin
      set_speed(sp[i]);
      check_bit("match", ex[i], speed_match_out);
    end
    // A slow decel keeps the ramped command far from the raw command.
    wr(vrss_pkg::OFF_DECEL, 32'h0000_0064);
    wr(vrss_pkg::OFF_CTRL, 32'h0000_0001);
    wr(vrss_pkg::OFF_VCMD, 32'h0000_0000);
    set_speed(16'h0000);
    check_bit("match raw ref", 1'b1, speed_match_out);
    rd(vrss_pkg::OFF_STATUS, q, e);
    check_word("status while ramping", 32'h0000_0006, q);
    wr(vrss_pkg::OFF_CTRL, 32'h0000_0000);
    set_speed(16'h0000);
    check_bit("match ramped ref", 1'b0, speed_match_out);
    wr(vrss_pkg::OFF_DECEL, 32'h0000_0000);
    $display("test match done");
  endtask

  task automatic t_ramp();
    wr(vrss_pkg::OFF_ACCEL, 32'h0000_0001);
    wr(vrss_pkg::OFF_VCMD, 32'h0000_0014);
    repeat (400) @(posedge pclk);
    #1 check_bit("accel midway", 1'b1,
      ramped_cmd > 0 && ramped_cmd < 20);
    repeat (200) @(posedge pclk);
    #1 check_word("accel end", 32'h0000_0014, 32'(ramped_cmd));
    wr(vrss_pkg::OFF_DECEL, 32'h0000_0002);
    wr(vrss_pkg::OFF_VCMD, 32'h0000_0000);
    repeat (900) @(posedge pclk);
    #1 check_bit("decel midway", 1'b1,
      ramped_cmd > 0 && ramped_cmd < 20);
    repeat (250) @(posedge pclk);
    #1 check_word("decel end", 32'h0000_0000, 32'(ramped_cmd));
    wr(vrss_pkg::OFF_ACCEL, 32'h0000_0000);
    wr(vrss_pkg::OFF_DECEL, 32'h0000_0000);
    $display("test ramp done");
  endtask

  task automatic wait_change(input logic signed [15:0] old);
    int n;
    n = 0;
    while (ramped_cmd === old && n < 26000) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask

  task automatic t_scurve();
    wr(vrss_pkg::OFF_SCURVE, 32'h0000_0002);
    // One full millisecond first, so the average holds a zero sample.
    repeat (25100) @(posedge pclk);
    // A negative target also exercises the sign handling of the average.
    wr(vrss_pkg::OFF_VCMD, 32'hFFFF_FF9C);
    wait_change(16'sh0000);
    check_word("scurve half", 32'hFFFF_FFCE, 32'(ramped_cmd));
    wait_change(16'shFFCE);
    check_word("scurve full", 32'hFFFF_FF9C, 32'(ramped_cmd));
    wr(vrss_pkg::OFF_SCURVE, 32'h0000_0000);
    $display("test scurve done");
  endtask

  initial begin
    presetn = 1'b0;
    motor_speed = 16'sh0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_pass();
    t_attain();
    t_match();
    t_ramp();
    t_scurve();
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire
